// ### hw/serial_clock_consts.svh
// Offsets, field positions, reset values and counts of the serial clock and frame core.
// Assumes inclusion by bare name from the design modules and the bench.
`ifndef SERIAL_CLOCK_CONSTS_SVH
`define SERIAL_CLOCK_CONSTS_SVH
`define OFS_BAUD     8'h00
`define OFS_CTRL     8'h04
`define OFS_TXDATA   8'h08
`define OFS_RXDATA   8'h0C
`define OFS_STATUS   8'h10
`define BAUD_RESET   16'h0040
`define CTRL_RESET   16'h0000
`define CTRL_SPEED   2
`define CTRL_INVERT  3
`define CTRL_CPHA    4
`define CTRL_ORDER   5
`define CTRL_STOP2   8
`define CTRL_TXEN    12
`define CTRL_RXEN    13
`define CTRL_OPEN_DRAIN 14
`define RX_VALID     9
`define RX_PERR      10
`define RX_FERR      11
`define SPS_NORMAL   5'h10
`define SPS_DOUBLE   5'h08
`define SPS_SYNC     5'h02
`define FRAC_STEP    17'h00040
`define SPI_BITS     4'h8
`define MIN_DBITS    4'h5
`endif

// ### hw/serial_clock_pkg.sv
// Types shared by the serial clock and frame core.
// Assumes the constants header is on the include path.
`default_nettype none
package serial_clock_pkg;
  typedef enum logic [1:0] {
    MODE_ASYNC  = 2'b00,
    MODE_MASTER = 2'b01,
    MODE_SLAVE  = 2'b10,
    MODE_SPI    = 2'b11
  } comm_mode_type;
  typedef enum logic [1:0] {
    PAR_NONE = 2'b00,
    PAR_RSVD = 2'b01,
    PAR_EVEN = 2'b10,
    PAR_ODD  = 2'b11
  } parity_select_type;
endpackage
`default_nettype wire

// ### hw/sample_clock_if.sv
// Carrier between the core and its divider and edge detector.
// Assumes one clock domain; all signals are sampled on ref_clk.
`default_nettype none
interface sample_clock_if;
  logic [15:0] divisor;
  logic        sync_mode;
  logic        tick;
  logic        slave;
  logic        transfer_clock_pin;
  logic        master_next;
  logic        invert;
  logic        lead;
  logic        trail;
  modport divider (input divisor, sync_mode, output tick);
  modport edges (input slave, transfer_clock_pin, master_next, invert, output lead, trail);
  modport core (output divisor, sync_mode, slave, transfer_clock_pin, master_next, invert,
                input tick, lead, trail);
endinterface
`default_nettype wire

// ### hw/frac_divider.sv
// Fractional divider producing one oversampling tick per programmed period.
// Assumes software keeps the divisor at or above 64 in asynchronous modes.
`include "serial_clock_consts.svh"
`default_nettype none
module frac_divider
  import serial_clock_pkg::*;
(
  input  wire logic      ref_clk, // Peripheral clock.
  input  wire logic      rst,     // Asynchronous reset, active high.
  sample_clock_if.divider sc      // Divisor in, tick out.
);
  logic [16:0] acc;
  logic [16:0] eff_div;
  logic [16:0] sum;
  logic        wrap;

  // Synchronous modes drop the fraction; a floor of one step keeps the sum bounded.
  assign eff_div = sc.sync_mode ? {1'b0, sc.divisor[15:6], 6'h00}   // [RULE_09]
                                : {1'b0, sc.divisor};
  assign sum     = acc + `FRAC_STEP;
  assign wrap    = (sum >= eff_div) || (eff_div < `FRAC_STEP);
  assign sc.tick = wrap;

  // The remainder carries into the next period, so the average rate is exact.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) acc <= 17'h00000;
    else if (eff_div < `FRAC_STEP || acc >= eff_div) acc <= 17'h00000;  // Drop stale remainder.
    else acc <= wrap ? sum - eff_div : sum;  // [RULE_24] [RULE_07]
  end

  property p_acc_bound;
    @(posedge ref_clk) disable iff (rst)
      (eff_div >= `FRAC_STEP && $stable(eff_div)) |-> acc < eff_div;
  endproperty
  a_acc_bound: assert property (p_acc_bound) else $error("Divider remainder out of range."); // [RULE_24]
endmodule
`default_nettype wire

// ### hw/xck_edges.sv
// Edge finder for the transfer clock, internal or taken from the pin.
// Assumes the pin is synchronous enough for a two-stage synchroniser.
`include "serial_clock_consts.svh"
`default_nettype none
module clock_edges
  import serial_clock_pkg::*;
(
  input  wire logic    ref_clk, // Peripheral clock.
  input  wire logic    rst,     // Asynchronous reset, active high.
  sample_clock_if.edges sc      // Clock sources in, edges out.
);
  logic s1;
  logic s2;
  logic prev;
  logic level;

  // Two stages before use; the pin must stay below a quarter of ref_clk.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1   <= 1'b0;
      s2   <= 1'b0;
      prev <= 1'b0;
    end else begin
      s1   <= sc.transfer_clock_pin;  // [RULE_12]
      s2   <= s1;
      prev <= level;
    end
  end

  // Inversion moves the internal rising edge to the falling pin edge.
  assign level    = sc.slave ? (s2 ^ sc.invert) : sc.master_next;  // [RULE_11] [RULE_16]
  assign sc.lead  = level & ~prev;
  assign sc.trail = ~level & prev;
endmodule
`default_nettype wire

// ### hw/serial_clock_frame.sv
// Clock generation and frame format core of the serial port, with an APB slave.
// Assumes a zero-wait APB master on ref_clk and pins synchronous to ref_clk.
//
// Added by the designer: the APB interface to the registers and the address map.
`include "serial_clock_consts.svh"
`default_nettype none
// Contract
// RULE_01: Software sets pins, divider, mode, then enables.
// RULE_02: Software may enable open drain first.
// RULE_03: Software keeps interrupts off during setup.
// RULE_04: Software changes settings only when idle.
// RULE_05: Five clocking modes from divider or pin.
// RULE_06: Divider holds 10 integer, 6 fraction bits.
// RULE_07: Async rate 64f/(S*div); sync f/(2*int).
// RULE_08: Samples per bit 16, 8, or 2.
// RULE_09: Synchronous modes ignore fractional divider bits.
// RULE_10: Software keeps rate within clock limits.
// RULE_11: Slave mode times bits from pin clock.
// RULE_12: Pin clock sampled; remote keeps below quarter.
// RULE_13: Double speed doubles rate, eight samples.
// RULE_14: Clock pin output as master, input as slave.
// RULE_15: Sample on edge opposite to change.
// RULE_16: Change rising, sample falling; inversion swaps.
// RULE_17: SPI master clock from divider only.
// RULE_18: SPI modes follow inversion and clock phase.
// RULE_19: Software never alters phase mid transfer.
// RULE_20: Start, 5-9 data, parity, 1-2 stops.
// RULE_21: Start low, stops high, idle high.
// RULE_22: Even parity one when ones odd.
// RULE_23: SPI frames eight bits, order selectable.
// RULE_24: Fraction averaged over successive periods.
module serial_clock_frame
  import serial_clock_pkg::*;
(
  input  wire logic        ref_clk, // Peripheral clock, 125 MHz.
  input  wire logic        rst,     // Asynchronous reset, active high.
  input  wire logic        psel,    // APB select.
  input  wire logic        penable, // APB access phase.
  input  wire logic        pwrite,  // APB write.
  input  wire logic [7:0]  paddr,   // APB byte address.
  input  wire logic [31:0] pwdata,  // APB write data.
  output logic [31:0]      prdata,  // APB read data.
  output logic             pready,  // APB ready.
  output logic             pslverr, // APB error on unmapped address.
  input  wire logic        rx_in,   // Receive line.
  output logic             tx_out,  // Transmit line level.
  output logic             tx_oe,   // Transmit line drive enable.
  input  wire logic        transfer_clock_in,  // Transfer clock pin input.
  output logic             transfer_clock_out, // Transfer clock pin output.
  output logic             transfer_clock_oe   // Transfer clock pin drive enable.
);
  sample_clock_if sc ();
  frac_divider u_div (.ref_clk(ref_clk), .rst(rst), .sc(sc.divider));
  clock_edges  u_edg (.ref_clk(ref_clk), .rst(rst), .sc(sc.edges));

  logic [15:0] baud_divisor;
  logic [15:0] ctrl;
  logic [11:0] tx_shift;
  logic [3:0]  tx_left;
  logic [4:0]  tx_sub;
  logic        have_sample;
  logic        master_clk;
  logic [11:0] rx_bits;
  logic [3:0]  rx_cnt;
  logic [4:0]  rx_sub;
  logic        rx_active;
  logic [8:0]  rx_data;
  logic        rx_valid;
  logic        rx_perr;
  logic        rx_ferr;

  // Bit reversal of the low n data bits selects the order on the line.
  function automatic logic [8:0] order_bits(input logic [8:0] d, input logic [3:0] n,
                                            input logic msb);
    logic [8:0] r;
    r = d;
    for (int i = 0; i < 9; i++) begin
      if (msb && i < int'(n)) r[i] = d[int'(n) - 1 - i];
    end
    return r;
  endfunction

  function automatic logic [8:0] data_mask(input logic [3:0] n);
    return 9'(10'h001 << n) - 9'h001;
  endfunction

  // Mode decoding.
  comm_mode_type     mode;
  parity_select_type par;
  logic       is_async, is_spi, is_master, is_slave;
  logic       par_on, par_odd, setup_lead, sample_ev, setup_ev;
  logic [4:0] sps;
  logic [3:0] dbits, flen, rx_len;
  assign mode      = comm_mode_type'(ctrl[1:0]);  // [RULE_05]
  assign par       = parity_select_type'(ctrl[7:6]);
  assign is_async  = (mode == MODE_ASYNC);
  assign is_spi    = (mode == MODE_SPI);
  assign is_master = (mode == MODE_MASTER) || is_spi;  // [RULE_17]
  assign is_slave  = (mode == MODE_SLAVE);
  assign sps       = !is_async ? `SPS_SYNC                             // [RULE_08]
                   : (ctrl[`CTRL_SPEED] ? `SPS_DOUBLE : `SPS_NORMAL);  // [RULE_13]
  assign dbits     = is_spi ? `SPI_BITS : ((ctrl[11:9] > 3'h4) ? 4'h8  // [RULE_23]
                   : `MIN_DBITS + {1'b0, ctrl[11:9]});                 // [RULE_20]
  assign par_on    = !is_spi && (par == PAR_EVEN || par == PAR_ODD);
  assign par_odd   = (par == PAR_ODD);
  assign rx_len    = is_spi ? `SPI_BITS : dbits + {3'h0, par_on} + 4'h2;
  assign flen      = is_spi ? `SPI_BITS : rx_len + {3'h0, ctrl[`CTRL_STOP2]};
  // Plain synchronous mode behaves as SPI phase one: setup on the leading edge.
  assign setup_lead = is_spi ? ctrl[`CTRL_CPHA] : 1'b1;                 // [RULE_18]
  assign sample_ev  = setup_lead ? sc.trail : sc.lead;                  // [RULE_15]
  assign setup_ev   = setup_lead ? sc.lead : sc.trail;

  // Clock path wiring; the divider always runs, the pin replaces it as slave.
  logic next_master_clk;
  assign next_master_clk = (is_master && sc.tick && (tx_left != 4'h0 || master_clk))
                         ? ~master_clk : (is_master ? master_clk : 1'b0);
  assign sc.divisor     = baud_divisor;  // [RULE_06]
  assign sc.sync_mode   = !is_async;
  assign sc.slave       = is_slave;      // [RULE_11]
  assign sc.transfer_clock_pin = transfer_clock_in;
  assign sc.master_next = next_master_clk;
  assign sc.invert      = ctrl[`CTRL_INVERT];

  // APB decode; a request is answered one cycle after its setup cycle.
  logic done_acc, wr, rd, mapped, load;
  logic [31:0] rd_mux;
  logic [8:0]  tx_data;
  logic [11:0] frame;
  assign done_acc = psel && penable && pready;
  assign wr       = done_acc && pwrite;
  assign rd       = done_acc && !pwrite;
  assign mapped   = paddr == `OFS_BAUD || paddr == `OFS_CTRL || paddr == `OFS_TXDATA
                 || paddr == `OFS_RXDATA || paddr == `OFS_STATUS;
  assign rd_mux   = (paddr == `OFS_BAUD)   ? {16'h0000, baud_divisor}
                  : (paddr == `OFS_CTRL)   ? {16'h0000, ctrl}
                  : (paddr == `OFS_RXDATA) ? {20'h00000, rx_ferr, rx_perr, rx_valid, rx_data}
                  : (paddr == `OFS_STATUS) ? {28'h0000000, rx_active, transfer_clock_out,
                                              rx_valid, tx_left != 4'h0 || master_clk}
                  : 32'h00000000;
  // A transmit write is dropped while a frame or its clock tail is still out.
  assign load     = wr && paddr == `OFS_TXDATA && ctrl[`CTRL_TXEN]
                 && tx_left == 4'h0 && !master_clk;
  assign tx_data  = order_bits(pwdata[8:0] & data_mask(dbits), dbits, ctrl[`CTRL_ORDER]);

  // Frame layout, least significant first: start, data, parity, stops, idle ones.
  always_comb begin
    frame = 12'hFFF;
    if (is_spi) frame = {4'hF, tx_data[7:0]};
    else begin
      frame[0] = 1'b0;  // [RULE_21]
      for (int i = 0; i < 9; i++) begin
        if (i < int'(dbits)) frame[i + 1] = tx_data[i];
      end
      if (par_on) frame[dbits + 4'h1] = (^tx_data) ^ par_odd;  // [RULE_22]
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      baud_divisor <= `BAUD_RESET;
      ctrl         <= `CTRL_RESET;
    end else if (wr && paddr == `OFS_BAUD) baud_divisor <= pwdata[15:0];
    else if (wr && paddr == `OFS_CTRL) ctrl <= pwdata[15:0];
  end

  // Transmit timing: async bits last sps ticks, sync bits move on setup edges.
  logic tx_adv;
  assign tx_adv = is_async ? (sc.tick && tx_left != 4'h0 && tx_sub == sps - 5'h01)
                : (setup_ev && have_sample && tx_left > 4'h1);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_shift    <= 12'hFFF;
      tx_left     <= 4'h0;
      tx_sub      <= 5'h00;
      have_sample <= 1'b0;
      master_clk  <= 1'b0;
    end else begin
      master_clk <= next_master_clk;
      if (load) begin
        tx_shift    <= frame;
        tx_left     <= flen;
        tx_sub      <= 5'h00;
        have_sample <= 1'b0;
      end else if (tx_adv) begin
        tx_shift    <= {1'b1, tx_shift[11:1]};
        tx_left     <= tx_left - 4'h1;
        tx_sub      <= 5'h00;
        have_sample <= 1'b0;
      end else if (is_async && sc.tick && tx_left != 4'h0) tx_sub <= tx_sub + 5'h01;
      else if (!is_async && sample_ev && tx_left != 4'h0) begin
        have_sample <= 1'b1;
        if (tx_left == 4'h1) tx_left <= 4'h0;
      end
    end
  end

  // Pins; wired-AND releases the line instead of driving it high.
  logic line;
  assign line = (tx_left != 4'h0) ? tx_shift[0] : 1'b1;  // [RULE_21]
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_out             <= 1'b1;
      tx_oe              <= 1'b0;
      transfer_clock_out <= 1'b0;
      transfer_clock_oe  <= 1'b0;
    end else begin
      tx_out             <= line;
      tx_oe              <= ctrl[`CTRL_TXEN] && !(ctrl[`CTRL_OPEN_DRAIN] && line);
      transfer_clock_out <= next_master_clk ^ ctrl[`CTRL_INVERT];  // [RULE_16]
      transfer_clock_oe  <= is_master;                             // [RULE_14]
    end
  end

  // Receive: async samples mid-bit from the oversampling ticks, sync on sample edges.
  logic [11:0] rx_frame;
  logic        rx_take, rx_last;
  logic [8:0]  rx_dec;
  assign rx_take  = ctrl[`CTRL_RXEN] && (is_async
                  ? (sc.tick && rx_active && rx_sub == ((rx_cnt == 4'h0)
                     ? {1'b0, sps[4:1]} - 5'h01 : sps - 5'h01))
                  : (sample_ev && (is_spi ? tx_left != 4'h0 : (rx_active || !rx_in))));
  assign rx_last  = rx_cnt == rx_len - 4'h1;
  assign rx_frame = (rx_bits & ~(12'h001 << rx_cnt)) | ({11'h000, rx_in} << rx_cnt);
  assign rx_dec   = order_bits(is_spi ? {1'b0, rx_frame[7:0]}
                             : rx_frame[9:1] & data_mask(dbits), dbits, ctrl[`CTRL_ORDER]);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_bits   <= 12'h000;
      rx_cnt    <= 4'h0;
      rx_sub    <= 5'h00;
      rx_active <= 1'b0;
    end else if (!ctrl[`CTRL_RXEN]) begin
      rx_cnt    <= 4'h0;
      rx_active <= 1'b0;
    end else if (is_async && sc.tick && !rx_active && !rx_in) begin
      rx_active <= 1'b1;
      rx_sub    <= 5'h00;
      rx_cnt    <= 4'h0;
    end else if (rx_take) begin
      rx_bits <= rx_frame;
      rx_sub  <= 5'h00;
      if ((is_async && rx_cnt == 4'h0 && rx_in) || rx_last) begin
        rx_active <= 1'b0;
        rx_cnt    <= 4'h0;
      end else begin
        rx_active <= !is_spi;
        rx_cnt    <= rx_cnt + 4'h1;
      end
    end else if (is_async && sc.tick && rx_active) rx_sub <= rx_sub + 5'h01;
  end

  // A completed frame wins over a read in the same cycle.
  logic rx_done;
  assign rx_done = rx_take && rx_last && !(is_async && rx_cnt == 4'h0 && rx_in);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_data  <= 9'h000;
      rx_valid <= 1'b0;
      rx_perr  <= 1'b0;
      rx_ferr  <= 1'b0;
    end else if (rx_done) begin
      rx_data  <= rx_dec;
      rx_valid <= 1'b1;
      rx_perr  <= par_on && (rx_frame[dbits + 4'h1] != ((^(rx_frame[9:1] & data_mask(dbits)))
                                                     ^ par_odd));
      rx_ferr  <= !is_spi && !rx_frame[rx_len - 4'h1];
    end else if (rd && paddr == `OFS_RXDATA) rx_valid <= 1'b0;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_uart_load;
    load && !is_spi;
  endsequence
  property p_idle_high;
    tx_left == 4'h0 |=> tx_out;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("Idle line not high."); // [RULE_21]
  property p_start_low;
    s_uart_load |=> ##1 !tx_out;  // The pin register trails the shift register by one cycle.
  endproperty
  a_start_low: assert property (p_start_low) else $error("Start bit not low."); // [RULE_21]
  property p_frame_len;
    s_uart_load |=> tx_left == $past(dbits) + $past({3'h0, par_on})
                   + 4'h2 + $past({3'h0, ctrl[`CTRL_STOP2]});
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("Frame length wrong."); // [RULE_20]
  property p_spi_len;
    load && is_spi |=> tx_left == 4'h8;
  endproperty
  a_spi_len: assert property (p_spi_len) else $error("SPI frame not eight bits."); // [RULE_23]
  property p_parity;
    (s_uart_load and par_on)
      |=> tx_shift[$past(dbits) + 4'h1] == ($past(^tx_data) ^ $past(par_odd));
  endproperty
  a_parity: assert property (p_parity) else $error("Parity bit wrong."); // [RULE_22]
  property p_clock_dir;
    ##1 (transfer_clock_oe == $past(is_master)) && !(transfer_clock_oe && $past(is_slave));
  endproperty
  a_clock_dir: assert property (p_clock_dir) else $error("Clock pin direction wrong."); // [RULE_14]
  property p_setup_rising;
    mode == MODE_MASTER && !ctrl[`CTRL_INVERT] && tx_adv |=> $rose(transfer_clock_out);
  endproperty
  a_setup_rising: assert property (p_setup_rising) else $error("Data moved off rising edge."); // [RULE_16]
  property p_sps;
    is_async && tx_left != 4'h0 |-> tx_sub < (ctrl[`CTRL_SPEED] ? 5'h08 : 5'h10);
  endproperty
  a_sps: assert property (p_sps) else $error("Samples per bit exceeded."); // [RULE_08]
  property p_no_clock_slave;
    is_slave |-> !master_clk ##1 !master_clk;
  endproperty
  a_no_clock_slave: assert property (p_no_clock_slave) else $error("Slave made its own clock."); // [RULE_11]
endmodule
`default_nettype wire

// ### test/serial_peer.sv
// Remote serial peer: reads frames off the transmit line, sends frames and pin clocks.
// Assumes the peripheral clock; the bench calls its tasks by hierarchical name.
`default_nettype none
module serial_peer (
  input  wire logic ref_clk,  // Peripheral clock.
  input  wire logic tx_line,  // Transmit line as seen on the wire.
  output var logic  rx_line,  // Receive line towards the block.
  output var logic  clock_line  // Transfer clock when the peer is master.
);
  timeunit 1ns;
  timeprecision 1ps;
  // The line rests high and the pin clock stands still between frames.
  initial begin
    rx_line = 1'b1;
    clock_line = 1'b0;
  end
  // Sends n bits, each held per cycles, never faster than the block can sample.
  task automatic send(input logic [15:0] bits, input int n, input int per);
    for (int i = 0; i < n; i++) begin
      rx_line <= bits[i];
      repeat (per) @(posedge ref_clk);
    end
    rx_line <= 1'b1;
  endtask
  // Waits for a start bit, then samples n bits at their middle; ok stays low on a hang.
  task automatic grab(input int n, input int per, output logic [15:0] bits, output logic ok);
    int t;
    bits = '1;  // Bits past the frame read as the idle level.
    ok = 1'b0;
    for (t = 0; t < 2000 && tx_line !== 1'b0; t++) @(posedge ref_clk);
    if (tx_line === 1'b0) begin
      ok = 1'b1;
      repeat (per / 2) @(posedge ref_clk);
      for (int i = 0; i < n; i++) begin
        bits[i] = tx_line;
        repeat (per) @(posedge ref_clk);
      end
    end
  endtask
  // Clocks bits in as remote master; four cycles a phase keeps it under a quarter.
  task automatic clock_in(input logic [15:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      clock_line <= 1'b1;
      rx_line    <= bits[i];
      repeat (4) @(posedge ref_clk);
      clock_line <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
    rx_line <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench for the serial clock and frame core.
// Assumes the design files and the constants header are compiled first.
`include "serial_clock_consts.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, rst, psel, penable, pwrite, rerr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic        pready, pslverr, tx_out, tx_oe, transfer_clock_out, transfer_clock_oe;
  wire         rx_in, transfer_clock_in, tx_line;
  int          n_errors, n_compared;
  // The transmit line has a pull-up, so a released or open-drain high reads 1.
  assign tx_line = tx_oe ? tx_out : 1'b1;
  always #4 ref_clk = ~ref_clk;
  serial_clock_frame i_serial_clock_frame (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_in(rx_in), .tx_out(tx_out), .tx_oe(tx_oe),
    .transfer_clock_in(transfer_clock_in), .transfer_clock_out(transfer_clock_out),
    .transfer_clock_oe(transfer_clock_oe));
  serial_peer i_serial_peer (.ref_clk(ref_clk), .tx_line(tx_line), .rx_line(rx_in),
    .clock_line(transfer_clock_in));
  task automatic conclude();
    $display("Counts: compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic fail(input string what);
    n_errors++;
    $display("MISMATCH %s expected completion seen timeout", what);
    conclude();
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer; the request is held until pready is seen high at an edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int t;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (t = 0; t < 20; t++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    if (t == 20) fail("pready");
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Settings change only once the transmitter has gone quiet.
  task automatic wait_idle();
    int t;
    for (t = 0; t < 500; t++) begin
      apb(1'b0, `OFS_STATUS, 32'h0);
      if (rdata[0] === 1'b0) break;
    end
    if (t == 500) fail("idle");
  endtask
  // Expected line bits of one frame, first bit first, and their count.
  function automatic int build(input logic [8:0] d, input logic [15:0] c,
                               output logic [15:0] b);
    int nd;
    int n;
    nd = (c[11:9] > 3'h4) ? 8 : 5 + int'(c[11:9]);
    b = 16'hFFFF;
    b[0] = 1'b0;
    for (int i = 0; i < nd; i++) b[1 + i] = c[5] ? d[nd - 1 - i] : d[i];
    n = nd + 1;
    if (c[7]) begin
      b[n] = (^(d & ~(9'h1FF << nd))) ^ c[6];
      n++;
    end
    return n + (c[8] ? 2 : 1);
  endfunction
  task automatic t_reset();
    check("tx idle", 32'h1, {31'h0, tx_out});
    apb(1'b0, `OFS_BAUD, 32'h0);
    check("baud reset", 32'h40, rdata);
    apb(1'b1, `OFS_BAUD, 32'hFFFF_FFC1);
    apb(1'b0, `OFS_BAUD, 32'h0);
    check("baud width", 32'hFFC1, rdata);
    apb(1'b1, `OFS_BAUD, 32'h40);
    apb(1'b0, 8'h14, 32'h0);
    check("unmapped error", 32'h1, {31'h0, rerr});
    $display("Test reset done");
  endtask
  // Normal, double speed, 7E2, 5O1 msb first, 9N1 and open-drain 8N1 frames at divisor 64.
  task automatic t_async_tx();
    logic [15:0] cfg [6];
    logic [15:0] got, exp;
    logic        ok;
    int          n;
    cfg = '{16'h1600, 16'h1604, 16'h1580, 16'h10E0, 16'h1800, 16'h5600};
    for (int k = 0; k < 6; k++) begin
      // Format and open drain go in before the transmitter is enabled; no interrupts exist.
      apb(1'b1, `OFS_CTRL, {16'h0, cfg[k] & 16'hEFFF});
      apb(1'b1, `OFS_CTRL, {16'h0, cfg[k]});
      apb(1'b1, `OFS_TXDATA, 32'h1A5);
      n = build(9'h1A5, cfg[k], exp);
      i_serial_peer.grab(n, cfg[k][2] ? 8 : 16, got, ok);
      if (ok !== 1'b1) fail("start bit");
      check("tx frame", {16'h0, exp}, {16'h0, got});
      wait_idle();
      check("tx drive at rest", {31'h0, !cfg[k][14]}, {31'h0, tx_oe});
    end
    $display("Test async transmit done");
  endtask
  task automatic t_async_rx();
    logic [15:0] b;
    int          n;
    apb(1'b1, `OFS_CTRL, 32'h2680);
    n = build(9'h03C, 16'h2680, b);
    i_serial_peer.send(b, n, 16);
    apb(1'b0, `OFS_RXDATA, 32'h0);
    check("rx even frame", 32'h23C, rdata);
    b[9] = ~b[9];
    i_serial_peer.send(b, n, 16);
    apb(1'b0, `OFS_RXDATA, 32'h0);
    check("rx parity error", 32'h63C, rdata);
    $display("Test async receive done");
  endtask
  // Sync master, then SPI with inverted pin; the fraction must not alter the clock.
  task automatic t_sync_clock();
    logic [15:0] cfg [2];
    logic        last;
    int          t, gap;
    cfg = '{16'h1601, 16'h160B};
    apb(1'b1, `OFS_BAUD, 32'h00FF);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, `OFS_CTRL, {16'h0, cfg[k]});
      apb(1'b1, `OFS_TXDATA, 32'h5A);
      check("clock drive", 32'h1, {31'h0, transfer_clock_oe});
      last = transfer_clock_out;
      for (t = 0; t < 50 && transfer_clock_out === last; t++) @(posedge ref_clk);
      last = transfer_clock_out;
      for (gap = 0; gap < 50 && transfer_clock_out === last; gap++) @(posedge ref_clk);
      check("clock half period", 32'h3, gap);
      wait_idle();
      check("clock rest", {31'h0, cfg[k][3]}, {31'h0, transfer_clock_out});
    end
    $display("Test sync clock done");
  endtask
  task automatic t_slave_rx();
    logic [15:0] b;
    int          n;
    apb(1'b1, `OFS_BAUD, 32'h40);
    apb(1'b1, `OFS_CTRL, 32'h2602);
    n = build(9'h0A5, 16'h2602, b);
    i_serial_peer.clock_in(b, n);
    check("clock input", 32'h0, {31'h0, transfer_clock_oe});
    repeat (6) @(posedge ref_clk);
    apb(1'b0, `OFS_RXDATA, 32'h0);
    check("slave rx", 32'h2A5, rdata);
    $display("Test slave receive done");
  endtask
  // Reset for ten cycles, then run every scenario in turn.
  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_errors = 0;
    n_compared = 0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_async_tx();
    t_async_rx();
    t_sync_clock();
    t_slave_rx();
    conclude();
  end
  // A hang anywhere ends the run as a failure.
  initial begin
    repeat (100000) @(posedge ref_clk);
    fail("watchdog");
  end
endmodule
`default_nettype wire
